// >>> window_palette_pkg.sv
// constants and carrier types for the window palette priority selector
package window_palette_pkg;

  localparam int unsigned NUM_WIN     = 16;
  localparam int unsigned COORD_W     = 12;

  // register select codes on the host port
  localparam logic [2:0] RS_ADDR_RAM_WR = 3'h0;
  localparam logic [2:0] RS_PALETTE     = 3'h1;
  localparam logic [2:0] RS_PIXEL_MASK  = 3'h2;
  localparam logic [2:0] RS_ADDR_RAM_RD = 3'h3;
  localparam logic [2:0] RS_ADDR_OVL_WR = 3'h4;
  localparam logic [2:0] RS_OVERLAY     = 3'h5;
  localparam logic [2:0] RS_CONTROL     = 3'h6;
  localparam logic [2:0] RS_ADDR_OVL_RD = 3'h7;

  // control register indices behind the address register
  localparam logic [7:0] IDX_WIN_LAST   = 8'h7F;
  localparam logic [7:0] IDX_VCOUNT_LO  = 8'h80;
  localparam logic [7:0] IDX_VCOUNT_HI  = 8'h81;
  localparam logic [7:0] IDX_CMD0       = 8'h82;
  localparam logic [7:0] IDX_CMD1       = 8'h83;
  localparam logic [7:0] IDX_FLOOD_LO   = 8'h84;
  localparam logic [7:0] IDX_FLOOD_HI   = 8'h85;

  // coordinate slots inside one window group
  localparam logic [1:0] SLOT_LEFT      = 2'h0;
  localparam logic [1:0] SLOT_RIGHT     = 2'h1;
  localparam logic [1:0] SLOT_TOP       = 2'h2;
  localparam logic [1:0] SLOT_BOTTOM    = 2'h3;

  // field positions
  localparam int unsigned CMD1_BANKED_BIT = 0;
  localparam int unsigned CMD1_COLOR8_BIT = 1;
  localparam int unsigned CMD1_SYNC_LSB   = 2;

  // values after reset, when the 8-bit mode input is low, and where the counters saturate
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [11:0] RST_COORD       = 12'h000;
  localparam logic [3:0]  OVL_PASS_ALL    = 4'hF;
  localparam logic [11:0] COUNT_MAX       = 12'hFFF;

  typedef struct packed {
    logic       wr_n;
    logic       rd_n;
    logic [2:0] rs;
    logic [7:0] data;
  } host_pins_t;

  typedef struct packed {
    logic [7:0] pix;
    logic [3:0] ovl;
    logic       sync_n;
    logic       blank_n;
  } pixel_in_t;

  typedef struct packed {
    logic [9:0] pal_addr;
    logic [3:0] overlay;
    logic       flood;
    logic       blank_n;
    logic       sync_n;
    logic [2:0] sync_en;
    logic       color8;
    logic       banked;
    logic [1:0] host_bank;
  } video_out_t;

  typedef struct packed {
    logic       is_win;
    logic [3:0] win;
    logic [1:0] slot;
    logic       high;
  } reg_sel_t;

endpackage

// >>> window_palette_priority_select.sv
// window priority encoder, palette selection and control registers
`timescale 1ns/1ps

module window_palette_priority_select (
  // clock and reset
  input  wire logic                           sys_clk_in,
  input  wire logic                           arst_n_in,
  // host port
  input  wire window_palette_pkg::host_pins_t host_in,
  output logic [7:0]                          host_data_out,
  output logic                                host_data_oe_out,
  // mode straps
  input  wire logic                           mode_8bit_in,
  input  wire logic                           window_select_in,
  // frame buffer, sampled on the system clock
  input  wire window_palette_pkg::pixel_in_t  pixel_in,
  // palette addressing
  output window_palette_pkg::video_out_t      video_out
);
  import window_palette_pkg::*;

  typedef struct packed {
    host_pins_t                 hs1;
    host_pins_t                 hs2;
    logic                       wr_prev;
    logic [1:0]                 ms1;
    logic [1:0]                 ms2;
    logic [7:0]                 addr;
    logic [7:0]                 rd_data;
    logic                       rd_oe;
    logic [15:0][3:0][7:0]      lo_shadow;
    logic [15:0][3:0][11:0]     coord;
    logic [15:0][3:0]           bank;
    logic [7:0]                 vc_lo;
    logic [11:0]                vcount;
    logic [7:0]                 mask;
    logic [7:0]                 cmd0;
    logic [4:0]                 cmd1;
    logic [15:0]                flood;
    pixel_in_t                  pix_q;
    logic                       sync_prev;
    logic [11:0]                hcount;
    logic [11:0]                line;
    logic [11:0]                low_cnt;
    logic                       vs_seen;
    video_out_t                 vout;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic reg_sel_t decode_idx(input logic [7:0] idx);
    reg_sel_t s;
    s.is_win = (idx <= IDX_WIN_LAST);
    s.win    = idx[6:3];
    s.slot   = idx[2:1];
    s.high   = idx[0];
    return s;
  endfunction

  // span test with order-free bounds; equal bounds never cover
  function automatic logic in_span(input logic [11:0] pos, input logic [11:0] a,
                                   input logic [11:0] b);
    logic [11:0] lo;
    logic [11:0] hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    return (a != b) && (pos >= lo) && (pos <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // window coverage

  logic [15:0] win_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
      assign win_hit[gi] = in_span(st_ff.hcount, st_ff.coord[gi][SLOT_LEFT],
                                   st_ff.coord[gi][SLOT_RIGHT]) &&
                           in_span(st_ff.line, st_ff.coord[gi][SLOT_TOP],
                                   st_ff.coord[gi][SLOT_BOTTOM]);
    end
  endgenerate

  logic       win_any;
  logic [3:0] win_idx;

  always_comb begin
    win_any = 1'b0;
    win_idx = 4'h0;
    for (int i = NUM_WIN - 1; i >= 0; i--) begin
      if (win_hit[i]) begin
        win_any = 1'b1;
        win_idx = 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic       wr_edge;
  logic       mode8;
  logic       encoder_on;
  logic       sync_fall;
  logic [11:0] cur_low;
  logic [7:0] pix_m;
  logic [3:0] ovl_m;
  logic [7:0] rd_val;
  reg_sel_t   wsel;
  reg_sel_t   rsel;

  // edge taken between second and third stage; first stage is never looked at
  assign wr_edge    = st_ff.hs2.wr_n && !st_ff.wr_prev;
  assign mode8      = st_ff.ms2[0];
  assign encoder_on = st_ff.ms2[0] && st_ff.ms2[1];
  assign sync_fall  = !st_ff.pix_q.sync_n && st_ff.sync_prev;
  assign wsel       = decode_idx(st_ff.addr);
  assign rsel       = decode_idx(st_ff.addr);
  assign pix_m      = st_ff.pix_q.pix & st_ff.mask;
  // overlay mask, ignored in six-bit mode
  assign ovl_m      = st_ff.pix_q.ovl & (mode8 ? st_ff.cmd0[3:0] : OVL_PASS_ALL);

  // host read data
  always_comb begin
    rd_val = RST_BYTE;
    case (st_ff.hs2.rs)
      RS_ADDR_RAM_WR, RS_ADDR_RAM_RD, RS_ADDR_OVL_WR, RS_ADDR_OVL_RD: begin
        rd_val = st_ff.addr;
      end
      RS_PIXEL_MASK: begin
        rd_val = st_ff.mask;
      end
      RS_CONTROL: begin
        if (rsel.is_win) begin
          if (!rsel.high) begin
            rd_val = st_ff.lo_shadow[rsel.win][rsel.slot];
          end else if (rsel.slot == SLOT_LEFT) begin
            rd_val = {st_ff.bank[rsel.win], st_ff.coord[rsel.win][rsel.slot][11:8]};
          end else begin
            rd_val = {4'h0, st_ff.coord[rsel.win][rsel.slot][11:8]};
          end
        end else begin
          case (st_ff.addr)
            IDX_VCOUNT_LO: rd_val = st_ff.vc_lo;
            IDX_VCOUNT_HI: rd_val = {4'h0, st_ff.vcount[11:8]};
            IDX_CMD0:      rd_val = st_ff.cmd0;
            IDX_CMD1:      rd_val = {3'h0, st_ff.cmd1};
            IDX_FLOOD_LO:  rd_val = st_ff.flood[7:0];
            IDX_FLOOD_HI:  rd_val = st_ff.flood[15:8];
            default:       rd_val = RST_BYTE;
          endcase
        end
      end
      // palette and overlay colour data live outside this block
      default: begin
        rd_val = RST_BYTE;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;

    // host pins and straps cross through two stages
    nxt_st.hs1     = host_in;
    nxt_st.hs2     = st_ff.hs1;
    nxt_st.wr_prev = st_ff.hs2.wr_n;
    nxt_st.ms1     = {window_select_in, mode_8bit_in};
    nxt_st.ms2     = st_ff.ms1;

    nxt_st.rd_oe   = !st_ff.hs2.rd_n;
    nxt_st.rd_data = !st_ff.hs2.rd_n ? rd_val : RST_BYTE;

    if (wr_edge) begin
      case (st_ff.hs2.rs)
        RS_ADDR_RAM_WR, RS_ADDR_RAM_RD, RS_ADDR_OVL_WR, RS_ADDR_OVL_RD: begin
          nxt_st.addr = st_ff.hs2.data;
        end
        RS_PIXEL_MASK: begin
          nxt_st.mask = st_ff.hs2.data;
        end
        RS_CONTROL: begin
          if (wsel.is_win) begin
            if (!wsel.high) begin
              nxt_st.lo_shadow[wsel.win][wsel.slot] = st_ff.hs2.data;
            end else begin
              // full coordinate loads on high write
              nxt_st.coord[wsel.win][wsel.slot] =
                {st_ff.hs2.data[3:0], st_ff.lo_shadow[wsel.win][wsel.slot]};
              // bank code kept beside left edge
              if (wsel.slot == SLOT_LEFT) begin
                nxt_st.bank[wsel.win] = st_ff.hs2.data[7:4];
              end
            end
          end else begin
            case (st_ff.addr)
              IDX_VCOUNT_LO: nxt_st.vc_lo = st_ff.hs2.data;
              IDX_VCOUNT_HI: nxt_st.vcount = {st_ff.hs2.data[3:0], st_ff.vc_lo};
              IDX_CMD0:      nxt_st.cmd0 = st_ff.hs2.data;
              IDX_CMD1:      nxt_st.cmd1 = st_ff.hs2.data[4:0];
              IDX_FLOOD_LO:  nxt_st.flood[7:0] = st_ff.hs2.data;
              IDX_FLOOD_HI:  nxt_st.flood[15:8] = st_ff.hs2.data;
              default:       nxt_st.flood = st_ff.flood;
            endcase
          end
        end
        default: begin
          nxt_st.addr = st_ff.addr;
        end
      endcase
    end

    // display position tracking
    nxt_st.pix_q     = pixel_in;
    nxt_st.sync_prev = st_ff.pix_q.sync_n;
    // pixel counter restarts at sync fall
    nxt_st.hcount    = sync_fall ? RST_COORD
                     : ((st_ff.hcount == COUNT_MAX) ? COUNT_MAX : st_ff.hcount + 12'h001);
    cur_low = sync_fall ? RST_COORD
            : ((st_ff.low_cnt == COUNT_MAX) ? COUNT_MAX : st_ff.low_cnt + 12'h001);
    if (st_ff.pix_q.sync_n) begin
      nxt_st.vs_seen = 1'b0;
      nxt_st.low_cnt = RST_COORD;
    end else begin
      nxt_st.low_cnt = cur_low;
    end
    // vertical interval after programmed low time
    if (!st_ff.pix_q.sync_n && !st_ff.vs_seen && cur_low == st_ff.vcount) begin
      nxt_st.vs_seen = 1'b1;
      nxt_st.line    = RST_COORD;
    end else if (sync_fall) begin
      nxt_st.line    = (st_ff.line == COUNT_MAX) ? COUNT_MAX : st_ff.line + 12'h001;
    end

    // pixel addressing
    nxt_st.vout.blank_n = st_ff.pix_q.blank_n;
    nxt_st.vout.sync_n  = st_ff.pix_q.sync_n;
    nxt_st.vout.flood   = 1'b0;
    nxt_st.vout.overlay = 4'h0;
    nxt_st.vout.pal_addr = {2'h0, pix_m};
    if (!st_ff.pix_q.blank_n) begin
      // blanked pixels ignore pixel and overlay inputs
      nxt_st.vout.pal_addr = 10'h000;
    end else if (!mode8) begin
      // six-bit mode uses bank zero only
      nxt_st.vout.overlay = ovl_m;
    end else if (!encoder_on) begin
      nxt_st.vout.overlay  = {2'h0, ovl_m[1:0]};
      nxt_st.vout.pal_addr = {ovl_m[3:2], pix_m};
    end else if (ovl_m != 4'h0) begin
      nxt_st.vout.overlay = ovl_m;
    end else if (win_any) begin
      nxt_st.vout.flood    = st_ff.flood[win_idx];
      nxt_st.vout.pal_addr = {st_ff.bank[win_idx][1:0], pix_m};
    end else begin
      nxt_st.vout.pal_addr = {2'h0, pix_m};
    end

    // command fields, disregarded in six-bit mode
    nxt_st.vout.host_bank = mode8 ? st_ff.cmd0[5:4] : 2'h0;
    nxt_st.vout.banked    = mode8 && st_ff.cmd1[CMD1_BANKED_BIT];
    nxt_st.vout.color8    = mode8 && st_ff.cmd1[CMD1_COLOR8_BIT];
    nxt_st.vout.sync_en   = mode8 ? st_ff.cmd1[CMD1_SYNC_LSB +: 3] : 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // clearing to zero is only for simulation hygiene; software must program
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
      // strobe stages rest at the idle level so no false edge follows release
      st_ff.hs1.wr_n <= 1'b1;
      st_ff.hs1.rd_n <= 1'b1;
      st_ff.hs2.wr_n <= 1'b1;
      st_ff.hs2.rd_n <= 1'b1;
      st_ff.wr_prev  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_data_out    = st_ff.rd_data;
  assign host_data_oe_out = st_ff.rd_oe;
  assign video_out        = st_ff.vout;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  chk_hcount_restart: assert property (sync_fall |=> st_ff.hcount == 12'h000)
    else $error("pixel counter not cleared after sync fall");

  // detection ties line counter to zero
  chk_vsync_detect: assert property (
    (!st_ff.pix_q.sync_n && !st_ff.vs_seen && cur_low == st_ff.vcount)
      |=> (st_ff.line == 12'h000 && st_ff.vs_seen))
    else $error("vertical interval not detected at programmed count");

  // coordinates change only on a high-byte write
  chk_coord_hold: assert property (
    !(wr_edge && st_ff.hs2.rs == RS_CONTROL && wsel.is_win && wsel.high)
      |=> $stable(st_ff.coord))
    else $error("coordinate changed without high-byte write");

  // upper nibble of right, top, bottom high reads zero
  chk_high_nibble_zero: assert property (
    (!st_ff.hs2.rd_n && st_ff.hs2.rs == RS_CONTROL && rsel.is_win && rsel.high &&
     rsel.slot != SLOT_LEFT) |=> host_data_out[7:4] == 4'h0)
    else $error("reserved high nibble read non-zero");

  chk_cmd1_top_zero: assert property (
    (!st_ff.hs2.rd_n && st_ff.hs2.rs == RS_CONTROL && st_ff.addr == IDX_CMD1)
      |=> host_data_out[7:5] == 3'h0)
    else $error("command1 top bits read non-zero");

  chk_overlay_win: assert property (
    (st_ff.pix_q.blank_n && encoder_on && ovl_m != 4'h0)
      |=> (video_out.overlay == $past(ovl_m) && !video_out.flood))
    else $error("overlay code did not override palette");

  chk_no_window_bank0: assert property (
    (st_ff.pix_q.blank_n && encoder_on && ovl_m == 4'h0 && !win_any)
      |=> video_out.pal_addr[9:8] == 2'h0)
    else $error("uncovered pixel left bank zero");

  // masked-off pixel bits never reach the address
  chk_mask_pixel: assert property (
    ##1 (video_out.pal_addr[7:0] & ~$past(st_ff.mask)) == 8'h00)
    else $error("masked pixel bit reached palette address");

  // six-bit mode always bank zero and no flood
  chk_mode6_bank: assert property (
    !mode8 |=> (video_out.pal_addr[9:8] == 2'h0 && !video_out.flood))
    else $error("six-bit mode used a window bank");

  cov_vsync: cover property (!st_ff.vs_seen ##1 st_ff.vs_seen);
  cov_window_hit: cover property (encoder_on && win_any && win_idx != 4'h0);
  cov_flood: cover property (video_out.flood && video_out.blank_n);
  cov_overlap: cover property (win_hit[0] && win_hit[1]);

endmodule // window_palette_priority_select

// >>> window_palette_host_fb_model.sv
// host port and frame buffer model for the window palette selector
`timescale 1ns/1ps
module window_palette_host_fb_model (
  // clock
  input  wire logic                      sys_clk_in,
  // host port
  output window_palette_pkg::host_pins_t host_out,
  input  wire logic [7:0]                host_data_in,
  input  wire logic                      host_oe_in,
  // frame buffer
  output window_palette_pkg::pixel_in_t  pixel_out
);
  import window_palette_pkg::*;

  logic rd_oe_seen;

  initial begin
    rd_oe_seen = 1'b0;
    host_out  = '{wr_n: 1'b1, rd_n: 1'b1, rs: 3'h0, data: 8'hA5};
    pixel_out = '{pix: 8'h00, ovl: 4'h0, sync_n: 1'b1, blank_n: 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // data and select held past the strobe rise
  task automatic wr(input logic [2:0] rs, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    host_out.rs   = rs;
    host_out.data = d;
    host_out.wr_n = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    host_out.wr_n = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    #1;
    // released bus shows the inverse, not a stale copy
    host_out.data = ~d;
  endtask

  task automatic rd(input logic [2:0] rs, output logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    host_out.rs   = rs;
    host_out.rd_n = 1'b0;
    repeat (5) @(posedge sys_clk_in);
    #1;
    // data stands while the strobe is low, so take it clear of the edge
    d          = host_data_in;
    rd_oe_seen = host_oe_in;
    host_out.rd_n = 1'b1;
    repeat (5) @(posedge sys_clk_in);
  endtask

  // index goes to the address register, then select 110
  task automatic ctl_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(RS_ADDR_RAM_WR, idx);
    wr(RS_CONTROL, d);
  endtask

  task automatic ctl_rd(input logic [7:0] idx, output logic [7:0] d);
    wr(RS_ADDR_RAM_WR, idx);
    rd(RS_CONTROL, d);
  endtask

  // low byte always before high byte
  task automatic coord(input logic [7:0] idx, input logic [11:0] v, input logic [3:0] top);
    ctl_wr(idx, v[7:0]);
    ctl_wr(idx + 8'h01, {top, v[11:8]});
  endtask

  task automatic px(input logic s, input logic [7:0] p, input logic [3:0] o);
    @(posedge sys_clk_in);
    #1;
    pixel_out.sync_n = s;
    pixel_out.pix    = p;
    pixel_out.ovl    = o;
  endtask
endmodule // window_palette_host_fb_model

// >>> window_palette_priority_select_tb_top.sv
// self-checking testbench for the window palette selector
`timescale 1ns/1ps
module window_palette_priority_select_tb_top;
  import window_palette_pkg::*;

  localparam logic [14:0] NONE = {10'h05A, 5'h00};

  logic       sys_clk;
  logic       arst_n;
  logic       mode_8bit;
  logic       window_select;
  host_pins_t host;
  pixel_in_t  pixel;
  logic [7:0] host_data;
  logic       host_oe;
  video_out_t video;
  logic [14:0] vid;
  logic [7:0] rv;
  int         error_cnt;
  int         checked;

  assign vid = {video.pal_addr, video.overlay, video.flood};

  window_palette_priority_select DUT (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .host_in(host),
    .host_data_out(host_data), .host_data_oe_out(host_oe), .mode_8bit_in(mode_8bit),
    .window_select_in(window_select), .pixel_in(pixel), .video_out(video)
  );

  window_palette_host_fb_model fb (
    .sys_clk_in(sys_clk), .host_out(host), .host_data_in(host_data), .host_oe_in(host_oe),
    .pixel_out(pixel)
  );

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cmp_pix(input logic [14:0] got, input logic [14:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic creg(input logic [7:0] idx, input logic [7:0] exp);
    fb.ctl_rd(idx, rv);
    cmp_reg(rv, exp, "readback");
    cmp_reg({7'h00, fb.rd_oe_seen}, 8'h01, "oe during read");
    cmp_reg({7'h00, host_oe}, 8'h00, "oe released");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    // left and right edges of every window programmed before use; spare windows hidden
    for (int w = 3; w < 16; w++) begin
      fb.coord(8'(w * 8), 12'h000, 4'h0);
      fb.coord(8'(w * 8 + 2), 12'h000, 4'h0);
    end
    fb.coord(8'h00, 12'd50, 4'h1);
    fb.coord(8'h02, 12'd100, 4'h0);
    fb.coord(8'h04, 12'd3, 4'h0);
    fb.coord(8'h06, 12'd6, 4'h0);
    fb.coord(8'h08, 12'd150, 4'h2);
    fb.coord(8'h0A, 12'd80, 4'hF);
    fb.coord(8'h0C, 12'd6, 4'hF);
    fb.coord(8'h0E, 12'd3, 4'h0);
    fb.coord(8'h10, 12'h000, 4'h3);
    fb.coord(8'h12, 12'hFA0, 4'h0);
    fb.coord(8'h14, 12'd4, 4'h0);
    fb.coord(8'h16, 12'd4, 4'h0);
    fb.coord(IDX_VCOUNT_LO, 12'd20, 4'hF);
    fb.wr(RS_PIXEL_MASK, 8'hFF);
    fb.ctl_wr(IDX_CMD0, 8'h2F);
    fb.ctl_wr(IDX_CMD1, 8'hFF);
    fb.ctl_wr(IDX_FLOOD_LO, 8'h02);
    fb.ctl_wr(IDX_FLOOD_HI, 8'h00);
    creg(8'h01, 8'h10);
    creg(8'h08, 8'h96);
    creg(8'h0B, 8'h00);
    creg(8'h0D, 8'h00);
    creg(IDX_VCOUNT_HI, 8'h00);
    creg(IDX_CMD1, 8'h1F);
    creg(IDX_FLOOD_LO, 8'h02);
    creg(8'h86, 8'h00);
    cmp_reg({3'h0, video.sync_en, video.color8, video.banked}, 8'h1F, "cfg");
    cmp_reg({6'h00, video.host_bank}, 8'h02, "host bank");
  endtask

  task automatic line(input int low, input logic chk, input logic [14:0] e70,
                      input logic [14:0] e92, input logic [14:0] e125);
    for (int c = 0; c < 250; c++) begin
      fb.px(c >= low, 8'h5A, 4'h0);
      if (chk && c == 2) cmp_reg({6'h00, video.blank_n, video.sync_n}, 8'h02, "sync");
      if (chk && c == 70) cmp_pix(vid, e70, "left span");
      if (chk && c == 92) cmp_pix(vid, e92, "overlap");
      if (chk && c == 125) cmp_pix(vid, e125, "swapped span");
      if (chk && c == 200) cmp_pix(vid, NONE, "uncovered");
    end
  endtask

  task automatic frame(input logic win);
    // vertical sync: low longer than the programmed 20 cycles
    line(40, 1'b0, NONE, NONE, NONE);
    for (int l = 1; l <= 8; l++) begin
      if (l == 4 && win) begin
        line(4, 1'b1, {10'h15A, 5'h00}, {10'h15A, 5'h00}, {10'h25A, 5'h01});
      end else begin
        line(4, l == 1 || l == 4 || l == 8, NONE, NONE, NONE);
      end
    end
  endtask

  task automatic t_ovl_window;
    repeat (3) fb.px(1'b1, 8'h5A, 4'h9);
    cmp_reg({4'h0, video.overlay}, 8'h09, "overlay wins");
  endtask

  task automatic t_contig;
    window_select = 1'b0;
    fb.wr(RS_PIXEL_MASK, 8'h0F);
    repeat (3) fb.px(1'b1, 8'hA5, 4'hE);
    cmp_pix(vid, {2'd3, 8'h05, 4'h2, 1'b0}, "contiguous");
    fb.ctl_wr(IDX_CMD0, 8'h23);
    repeat (3) fb.px(1'b1, 8'hA5, 4'hE);
    cmp_pix(vid, {2'd0, 8'h05, 4'h2, 1'b0}, "overlay mask");
    fb.wr(RS_PIXEL_MASK, 8'hFF);
    fb.ctl_wr(IDX_CMD0, 8'h2F);
    window_select = 1'b1;
  endtask

  task automatic t_sixbit;
    mode_8bit = 1'b0;
    repeat (4) fb.px(1'b1, 8'h5A, 4'h0);
    cmp_reg({3'h0, video.sync_en, video.color8, video.banked}, 8'h00, "cfg off");
    cmp_reg({6'h00, video.host_bank}, 8'h00, "bank off");
    for (int o = 1; o < 16; o++) begin
      repeat (3) fb.px(1'b1, 8'h5A, 4'(o));
      cmp_reg({4'h0, video.overlay}, 8'(o), "overlay code");
    end
    frame(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt     = 0;
    checked       = 0;
    arst_n        = 1'b0;
    mode_8bit     = 1'b1;
    window_select = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_reg({7'h00, host_oe}, 8'h00, "oe after reset");
    t_regs();
    frame(1'b1);
    t_ovl_window();
    t_contig();
    t_sixbit();
    finish_test();
  end

  // watchdog: whole run needs well under 15000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end
endmodule // window_palette_priority_select_tb_top
